// [verilog/wit_cfg.svh]
// constants for the watchdog interval timer: addresses, keys, fields, resets, counts
`ifndef WIT_CFG_SVH
`define WIT_CFG_SVH
// ************************************************************
// register addresses and write keys
// ************************************************************
`define WIT_CNT_ADDR 32'hFFFFFF84
`define WIT_CSR_ADDR 32'hFFFFFF86
`define WIT_CNT_KEY 8'h5A
`define WIT_CSR_KEY 8'hA5
// ************************************************************
// control/status field positions
// ************************************************************
`define WIT_TME_BIT 7
`define WIT_MODE_BIT 6
`define WIT_RESET_KIND_SELECT_BIT 5
`define WIT_WATCHDOG_OVERFLOW_FLAG_BIT 4
`define WIT_INTERVAL_OVERFLOW_FLAG_BIT 3
`define WIT_CKS_MSB 2
`define WIT_CKS_LSB 0
// ************************************************************
// reset values and counter marks
// ************************************************************
`define WIT_CNT_RST 8'h00
`define WIT_CSR_RST 8'h00
`define WIT_CNT_MAX 8'hFF
`define WIT_REENTER_CNT 8'h80
`define WIT_MAN_RST_CYCLES 3'h5
`define WIT_PRE_RST 12'h000
`endif

// [verilog/wit_pkg.sv]
// types shared by the watchdog interval timer
package wit_pkg;
	// access size of a bus transfer
	typedef enum logic [1:0] {
		WIT_SZ_BYTE,
		WIT_SZ_WORD,
		WIT_SZ_LONG
	} wit_size_t;
	// one register access; a word write carries key in [15:8], data in [7:0]
	typedef struct packed {
		logic sel;
		logic wr;
		wit_size_t size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} wit_bus_req_t;
	// events from clock generator and standby control
	typedef struct packed {
		logic standby_enter;
		logic wake_event;
		logic standby_select_bit;
		logic pll_change;
		logic ratio_extra_tick;
	} wit_sys_in_t;
	// operating phase of the counter
	typedef enum logic [2:0] {
		WIT_ST_NORMAL,
		WIT_ST_STANDBY_SELECT_BIT,
		WIT_ST_WAKE,
		WIT_ST_POST,
		WIT_ST_FREQ,
		WIT_ST_FTAIL
	} wit_state_t;
	// whole state of the timer
	typedef struct packed {
		wit_state_t st;
		logic [7:0] cnt;
		logic [7:0] csr;
		logic [11:0] pre;
		logic rout_b;
		logic por_hold;
		logic [2:0] man_cnt;
		logic por_req;
		logic man_req;
		logic irq;
		logic resume;
		logic reenter;
		logic [7:0] rdata;
	} wit_regs_t;
endpackage

// [verilog/wit_timer.sv]
// watchdog / interval timer with keyed registers and settling-time counting
`timescale 1ns/10ps
`include "wit_cfg.svh"

module wit_timer (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wit_pkg::wit_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wit_pkg::wit_sys_in_t sys_in,
	output logic reset_output_pin_b,
	output logic por_req,
	output logic manual_req,
	output logic interval_irq,
	output logic clock_resume,
	output logic standby_reenter
);
	// ************************************************************
	// helpers
	// ************************************************************
	// prescaler mask per clock select; tick when masked bits are all ones
	function automatic logic [11:0] div_mask(input logic [2:0] cks);
		unique case (cks)
			3'h0: div_mask = 12'h000;
			3'h1: div_mask = 12'h003;
			3'h2: div_mask = 12'h00F;
			3'h3: div_mask = 12'h01F;
			3'h4: div_mask = 12'h03F;
			3'h5: div_mask = 12'h0FF;
			3'h6: div_mask = 12'h3FF;
			3'h7: div_mask = 12'hFFF;
		endcase
	endfunction

	// reset image of the whole state
	localparam wit_pkg::wit_regs_t RST_VAL = '{
		st: wit_pkg::WIT_ST_NORMAL,
		cnt: `WIT_CNT_RST,
		csr: `WIT_CSR_RST,
		pre: `WIT_PRE_RST,
		rout_b: 1'b1,
		por_hold: 1'b0,
		man_cnt: 3'h0,
		por_req: 1'b0,
		man_req: 1'b0,
		irq: 1'b0,
		resume: 1'b0,
		reenter: 1'b0,
		rdata: 8'h00
	};

	wit_pkg::wit_regs_t s_r; // registered state
	wit_pkg::wit_regs_t s_nxt; // next state

	// ************************************************************
	// access decode
	// ************************************************************
	logic word_wr; // word-sized write strobe
	logic cnt_wr; // keyed counter write
	logic csr_wr; // keyed control/status write
	logic byte_rd; // byte-sized read strobe
	logic tick; // count clock tick
	logic timer_run; // timer run bit
	logic wd_mode; // watchdog mode selected
	logic settle; // counting for clock settling
	logic count_en; // counter advances this cycle
	logic ovf; // wrap ff to 00 this cycle
	logic ovf_norm; // overflow in normal operation
	logic ovf_settle; // overflow ending a settling period

	assign word_wr = bus_req.sel && bus_req.wr && (bus_req.size == wit_pkg::WIT_SZ_WORD);
	// key in the upper byte gates the store; other sizes fall through
	assign cnt_wr = word_wr && (bus_req.addr == `WIT_CNT_ADDR)
		&& (bus_req.wdata[15:8] == `WIT_CNT_KEY);
	assign csr_wr = word_wr && (bus_req.addr == `WIT_CSR_ADDR)
		&& (bus_req.wdata[15:8] == `WIT_CSR_KEY);
	assign byte_rd = bus_req.sel && !bus_req.wr && (bus_req.size == wit_pkg::WIT_SZ_BYTE);

	assign timer_run = s_r.csr[`WIT_TME_BIT];
	assign wd_mode = s_r.csr[`WIT_MODE_BIT];
	// selected division of the peripheral clock
	assign tick = ((s_r.pre & div_mask(s_r.csr[`WIT_CKS_MSB:`WIT_CKS_LSB]))
		== div_mask(s_r.csr[`WIT_CKS_MSB:`WIT_CKS_LSB]));
	// settling phases count regardless of the run bit; plain standby does not
	assign settle = (s_r.st == wit_pkg::WIT_ST_WAKE) || (s_r.st == wit_pkg::WIT_ST_POST)
		|| (s_r.st == wit_pkg::WIT_ST_FREQ) || (s_r.st == wit_pkg::WIT_ST_FTAIL);
	// run bit gates normal counting
	assign count_en = tick && ((s_r.st == wit_pkg::WIT_ST_NORMAL) ? timer_run : settle);
	// wrap detection
	assign ovf = count_en && (s_r.cnt == `WIT_CNT_MAX);
	assign ovf_norm = ovf && (s_r.st == wit_pkg::WIT_ST_NORMAL);
	// only the two settling phases resume the clock; a wrap after resume is not one
	assign ovf_settle = ovf && ((s_r.st == wit_pkg::WIT_ST_WAKE)
		|| (s_r.st == wit_pkg::WIT_ST_FREQ));

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_nxt = s_r;
		// prescaler runs free so the tick phase never depends on software
		s_nxt.pre = s_r.pre + 12'h001;
		// event outputs are single-cycle
		s_nxt.por_req = 1'b0;
		s_nxt.man_req = 1'b0;
		s_nxt.irq = 1'b0;
		s_nxt.resume = 1'b0;
		s_nxt.reenter = 1'b0;

		// counter advance; wraps to 00 and keeps counting
		if (count_en) begin
			s_nxt.cnt = s_r.cnt + 8'h01;
		end
		// software write wins over a same-cycle tick
		if (cnt_wr) begin
			s_nxt.cnt = bus_req.wdata[7:0];
		end
		// keyed store of control/status
		if (csr_wr) begin
			s_nxt.csr = bus_req.wdata[7:0];
		end

		// normal overflow: flag of active mode, set wins over write
		if (ovf_norm) begin
			if (wd_mode) begin
				s_nxt.csr[`WIT_WATCHDOG_OVERFLOW_FLAG_BIT] = 1'b1;
				// reset kind from bit 5
				if (s_r.csr[`WIT_RESET_KIND_SELECT_BIT]) begin
					s_nxt.man_req = 1'b1;
					s_nxt.man_cnt = `WIT_MAN_RST_CYCLES;
				end else begin
					s_nxt.por_req = 1'b1;
					s_nxt.por_hold = 1'b1;
				end
			end else begin
				s_nxt.csr[`WIT_INTERVAL_OVERFLOW_FLAG_BIT] = 1'b1;
				s_nxt.irq = 1'b1;
			end
		end

		// reset output pulse lengths
		if (s_r.por_hold && tick && !ovf_norm) begin
			// power-on pulse ends at the next count tick
			s_nxt.por_hold = 1'b0;
		end
		if (s_r.man_cnt != 3'h0 && !ovf_norm) begin
			s_nxt.man_cnt = s_r.man_cnt - 3'h1;
		end
		// pin follows the next-state holds so it falls together with the request
		s_nxt.rout_b = !(s_nxt.por_hold || (s_nxt.man_cnt != 3'h0));

		// standby and frequency-change phases
		unique case (s_r.st)
			wit_pkg::WIT_ST_NORMAL: begin
				// pll change wins if both arrive; the clock stops either way
				if (sys_in.pll_change) begin
					s_nxt.st = wit_pkg::WIT_ST_FREQ;
				end else if (sys_in.standby_enter) begin
					s_nxt.st = wit_pkg::WIT_ST_STANDBY_SELECT_BIT;
				end
			end
			wit_pkg::WIT_ST_STANDBY_SELECT_BIT: begin
				// only an nmi edge or interrupt starts settling
				if (sys_in.wake_event) begin
					s_nxt.st = wit_pkg::WIT_ST_WAKE;
				end
			end
			wit_pkg::WIT_ST_WAKE: begin
				// resume clock, no flag, csr kept
				if (ovf_settle) begin
					s_nxt.resume = 1'b1;
					s_nxt.st = wit_pkg::WIT_ST_POST;
				end
			end
			wit_pkg::WIT_ST_POST: begin
				// handler clears standby select to stop; else reenter at 80
				if (!sys_in.standby_select_bit) begin
					s_nxt.st = wit_pkg::WIT_ST_NORMAL;
				end else if (s_nxt.cnt == `WIT_REENTER_CNT && count_en) begin
					s_nxt.reenter = 1'b1;
					s_nxt.st = wit_pkg::WIT_ST_STANDBY_SELECT_BIT;
				end
			end
			wit_pkg::WIT_ST_FREQ: begin
				// clock resumes, flag untouched
				if (ovf_settle) begin
					s_nxt.resume = 1'b1;
					// ratio decides a stop at 00 or 01
					s_nxt.st = sys_in.ratio_extra_tick ? wit_pkg::WIT_ST_FTAIL
						: wit_pkg::WIT_ST_NORMAL;
				end
			end
			wit_pkg::WIT_ST_FTAIL: begin
				// one more tick carries 00 to 01, then stop
				if (count_en) begin
					s_nxt.st = wit_pkg::WIT_ST_NORMAL;
				end
			end
			default: begin
				// unused codes fall back to normal operation
				s_nxt.st = wit_pkg::WIT_ST_NORMAL;
			end
		endcase

		// byte read answers with current contents, unmapped reads zero
		if (byte_rd) begin
			if (bus_req.addr == `WIT_CNT_ADDR) begin
				s_nxt.rdata = s_r.cnt;
			end else if (bus_req.addr == `WIT_CSR_ADDR) begin
				s_nxt.rdata = s_r.csr;
			end else begin
				s_nxt.rdata = 8'h00;
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	// rst_b is the power-on pin; nothing else clears cnt or csr
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_r <= RST_VAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign bus_rdata = s_r.rdata;
	assign reset_output_pin_b = s_r.rout_b;
	assign por_req = s_r.por_req;
	assign manual_req = s_r.man_req;
	assign interval_irq = s_r.irq;
	assign clock_resume = s_r.resume;
	assign standby_reenter = s_r.reenter;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	por_clear_a: assert property ($rose(rst_b) |-> s_r.cnt == 8'h00 && s_r.csr == 8'h00)
		else $error("counter or csr not cleared by power-on reset");
	key_write_a: assert property (cnt_wr |=> s_r.cnt == $past(bus_req.wdata[7:0]))
		else $error("keyed counter write not stored");
	bad_write_a: assert property (bus_req.sel && bus_req.wr && !csr_wr && !ovf_norm
		|=> s_r.csr == $past(s_r.csr))
		else $error("control/status changed without keyed write");
	stop_hold_a: assert property (s_r.st == wit_pkg::WIT_ST_NORMAL && !timer_run && !cnt_wr
		|=> $stable(s_r.cnt))
		else $error("counter moved while stopped");
	div_one_a: assert property (s_r.st == wit_pkg::WIT_ST_NORMAL && timer_run && !cnt_wr
		&& s_r.csr[2:0] == 3'h0 |=> s_r.cnt == $past(s_r.cnt) + 8'h01)
		else $error("undivided clock did not count every cycle");
	wd_flag_a: assert property (ovf_norm && wd_mode |=> s_r.csr[4] && !interval_irq)
		else $error("watchdog overflow flag missing");
	it_flag_a: assert property (ovf_norm && !wd_mode
		|=> s_r.csr[3] && interval_irq && !por_req && !manual_req)
		else $error("interval overflow not signalled");
	// five low cycles counted from the request, then high again
	man_len_a: assert property (manual_req
		|-> !reset_output_pin_b [*5] ##1 reset_output_pin_b)
		else $error("manual reset pulse length wrong");
	settle_noflag_a: assert property (ovf_settle && !csr_wr
		|=> clock_resume && s_r.csr == $past(s_r.csr))
		else $error("settling overflow disturbed csr");
	standby_select_bit_idle_a: assert property (s_r.st == wit_pkg::WIT_ST_STANDBY_SELECT_BIT && !cnt_wr
		|=> $stable(s_r.cnt))
		else $error("counter moved in standby before wake");
	// a watchdog reset request always pulls the reset output low
	rout_low_a: assert property (por_req || manual_req
		|-> !reset_output_pin_b)
		else $error("reset output not low during reset request");
	// power-on pulse lets go at the first count tick after the request
	por_len_a: assert property (por_req && tick && !ovf_norm && s_r.man_cnt == 3'h0
		|=> reset_output_pin_b)
		else $error("power-on reset pulse too long");
	// reset kind follows the select bit held at overflow
	wd_kind_a: assert property (ovf_norm && wd_mode
		|=> manual_req == $past(s_r.csr[`WIT_RESET_KIND_SELECT_BIT])
		&& por_req != $past(s_r.csr[`WIT_RESET_KIND_SELECT_BIT]))
		else $error("watchdog reset kind wrong");
	// byte read of the counter returns the value it held when taken
	rd_cnt_a: assert property (byte_rd && bus_req.addr == `WIT_CNT_ADDR
		|=> bus_rdata == $past(s_r.cnt))
		else $error("counter read data wrong");
	// re-entry to standby happens only with the count at its mark
	reenter_at_a: assert property (standby_reenter
		|-> s_r.cnt == `WIT_REENTER_CNT && s_r.st == wit_pkg::WIT_ST_STANDBY_SELECT_BIT)
		else $error("standby re-entry away from its mark");
	// the extra settling tick leaves the counter parked at 01
	ftail_stop_a: assert property (s_r.st == wit_pkg::WIT_ST_FTAIL
		&& count_en && !cnt_wr && s_r.cnt == 8'h00
		|=> s_r.cnt == 8'h01 && s_r.st == wit_pkg::WIT_ST_NORMAL)
		else $error("pll settling did not stop at 01");
	// only a wake event starts the settling count out of standby
	wake_start_a: assert property (s_r.st == wit_pkg::WIT_ST_STANDBY_SELECT_BIT
		&& sys_in.wake_event
		|=> s_r.st == wit_pkg::WIT_ST_WAKE)
		else $error("wake event did not start settling");
	// a pll change from normal operation starts the settling count
	freq_enter_a: assert property (s_r.st == wit_pkg::WIT_ST_NORMAL
		&& sys_in.pll_change |=> s_r.st == wit_pkg::WIT_ST_FREQ)
		else $error("pll change did not start settling");
	// plain standby entry parks the counter without counting
	standby_select_bit_enter_a: assert property (s_r.st == wit_pkg::WIT_ST_NORMAL
		&& sys_in.standby_enter && !sys_in.pll_change |=> s_r.st == wit_pkg::WIT_ST_STANDBY_SELECT_BIT)
		else $error("standby entry not taken");
	// interval request is a single-cycle event
	irq_pulse_a: assert property (interval_irq |=> !interval_irq)
		else $error("interval request longer than one cycle");

	// main scenarios reached
	wd_reset_c: cover property (ovf_norm && wd_mode);
	it_irq_c: cover property (interval_irq);
	wake_c: cover property (s_r.st == wit_pkg::WIT_ST_WAKE ##[1:300] clock_resume);
	freq_c: cover property (s_r.st == wit_pkg::WIT_ST_FTAIL);
	man_rst_c: cover property (manual_req);
endmodule // wit_timer

// [sim/wit_timer_tb.sv]
// self-checking bench for the watchdog interval timer
`timescale 1ns/10ps
`include "wit_cfg.svh"
module wit_timer_tb;
	// ************************************************************
	// signals, design instance, clock
	// ************************************************************
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0; // power-on pin, low at start
	wit_pkg::wit_bus_req_t bus_req = '0;
	wit_pkg::wit_sys_in_t sys_in = '0;
	logic [7:0] bus_rdata;
	logic reset_output_pin_b, por_req, manual_req, interval_irq, clock_resume, standby_reenter;
	logic [4:0] ev; // all event pulses side by side
	logic [7:0] rq[$]; // expected read data, oldest first
	logic [4:0] eq[$]; // expected event pulses, oldest first
	logic rd_pend = 1'b0;
	logic [7:0] lfsr = 8'h56; // seed 86
	logic [7:0] prev = 8'h00; // last counter value stored
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	int k;
	int low;
	int divs[8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
	assign ev = {por_req, manual_req, interval_irq, clock_resume, standby_reenter};
	wit_timer wit_timer_inst (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .sys_in(sys_in), .reset_output_pin_b(reset_output_pin_b),
		.por_req(por_req), .manual_req(manual_req), .interval_irq(interval_irq),
		.clock_resume(clock_resume), .standby_reenter(standby_reenter));
	// 20 ns period
	always #10 clk_sys = ~clk_sys;
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic bit diff(input logic [7:0] a, input logic [7:0] b);
		total_checks++;
		return a !== b;
	endfunction
	task automatic bad(input string m);
		fails++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	// shifter feeding random register values
	function automatic logic [7:0] nxt(input logic [7:0] l);
		return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
	endfunction
	// one access, raised after an edge and held across the taking edge
	task automatic bus(input logic w, input wit_pkg::wit_size_t sz, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		#1;
		bus_req = '{sel: 1'b1, wr: w, size: sz, addr: a, wdata: d};
		@(posedge clk_sys);
		#1;
		bus_req.sel = 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] key, input logic [7:0] d);
		// upper half is random and must be ignored by the keyed decode
		bus(1'b1, wit_pkg::WIT_SZ_WORD, a, {lfsr, ~lfsr, key, d});
	endtask
	task automatic rd(input logic [31:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, wit_pkg::WIT_SZ_BYTE, a, 32'h00000000);
	endtask
	// one-cycle pulse on a standby/pll input bit
	task automatic pulse(input int b);
		@(posedge clk_sys);
		#1;
		sys_in[b] = 1'b1;
		@(posedge clk_sys);
		#1;
		sys_in[b] = 1'b0;
	endtask
	// bounded wait for any event pulse; k holds the edges waited
	task automatic wait_ev(input int lim);
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (ev === 5'h00 && k < lim);
		if (diff(8'(k < lim), 8'h01)) bad("event missing");
	endtask
	// watchdog overflow from FF with cks 0 and the reset pin width
	task automatic wd_ovf(input logic reset_kind_select, input logic [4:0] e, input int wid);
		wr(`WIT_CNT_ADDR, `WIT_CNT_KEY, 8'hFF);
		eq.push_back(e);
		wr(`WIT_CSR_ADDR, `WIT_CSR_KEY, 8'hC0 | {2'b00, reset_kind_select, 5'h00});
		wait_ev(20);
		low = 0;
		while (reset_output_pin_b === 1'b0 && low < 20) begin
			low++;
			@(posedge clk_sys);
			#1;
		end
		if (diff(8'(low), 8'(wid))) bad("reset output width");
		rd(`WIT_CSR_ADDR, 8'hD0 | {2'b00, reset_kind_select, 5'h00});
		wr(`WIT_CSR_ADDR, `WIT_CSR_KEY, 8'h00);
	endtask
	task automatic tally_and_finish;
		if (rq.size() != 0 || eq.size() != 0) bad("expected results never seen");
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ************************************************************
	// watcher: pops the oldest note when a result shows
	// ************************************************************
	always @(negedge clk_sys) begin
		cyc++;
		// far above the roughly 8.5k cycles the sequence needs
		if (cyc > 40000) begin
			bad("timeout");
			tally_and_finish();
		end
		if (!rst_b) begin
			rd_pend = 1'b0;
		end else begin
			if (rd_pend) begin
				if (rq.size() == 0) bad("unexpected read");
				else if (diff(bus_rdata, rq.pop_front())) bad("read data");
			end
			rd_pend = bus_req.sel && !bus_req.wr && bus_req.size == wit_pkg::WIT_SZ_BYTE;
			if (ev !== 5'h00) begin
				if (eq.size() == 0) bad("unexpected event");
				else if (diff({3'h0, ev}, {3'h0, eq.pop_front()})) bad("event kind");
			end
		end
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (8) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		rd(`WIT_CNT_ADDR, 8'h00);
		rd(`WIT_CSR_ADDR, 8'h00);
		rd(32'hFFFFFF88, 8'h00); // unmapped place
		// refused writes leave the stopped counter alone
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt(lfsr);
			bus(1'b1, wit_pkg::WIT_SZ_BYTE, `WIT_CNT_ADDR, {16'h0000, `WIT_CNT_KEY, lfsr});
			bus(1'b1, wit_pkg::WIT_SZ_LONG, `WIT_CNT_ADDR, {16'h0000, `WIT_CNT_KEY, lfsr});
			wr(`WIT_CNT_ADDR, `WIT_CNT_KEY ^ (lfsr | 8'h01), lfsr);
			wr(`WIT_CSR_ADDR, `WIT_CNT_KEY, lfsr);
			rd(`WIT_CNT_ADDR, prev);
			rd(`WIT_CSR_ADDR, 8'h00);
			wr(`WIT_CNT_ADDR, `WIT_CNT_KEY, lfsr);
			prev = lfsr;
			rd(`WIT_CNT_ADDR, lfsr);
			wr(`WIT_CSR_ADDR, `WIT_CSR_KEY, lfsr & 8'h7F);
			rd(`WIT_CSR_ADDR, lfsr & 8'h7F);
			wr(`WIT_CSR_ADDR, `WIT_CSR_KEY, 8'h00);
		end
		// interval mode at every division: overflow gap after reloading FF
		for (int c = 0; c < 8; c++) begin
			wr(`WIT_CNT_ADDR, `WIT_CNT_KEY, 8'hFF);
			eq.push_back(5'b00100);
			eq.push_back(5'b00100);
			wr(`WIT_CSR_ADDR, `WIT_CSR_KEY, 8'h80 | 8'(c)); // cks set from stopped
			wait_ev(5000);
			wr(`WIT_CNT_ADDR, `WIT_CNT_KEY, 8'hFF);
			wait_ev(5000);
			if (diff(8'((k + 2) >> 4), 8'(((divs[c] == 1) ? 3 : divs[c]) >> 4))) bad("div hi");
			if (diff(8'(k + 2), 8'((divs[c] == 1) ? 3 : divs[c]))) bad("division");
			rd(`WIT_CSR_ADDR, 8'h88 | 8'(c));
			wr(`WIT_CSR_ADDR, `WIT_CSR_KEY, 8'h00);
		end
		wd_ovf(1'b0, 5'b10000, 1);
		wd_ovf(1'b1, 5'b01000, `WIT_MAN_RST_CYCLES);
		// standby exit settling, re-entry at 80, then exit to normal
		wr(`WIT_CNT_ADDR, `WIT_CNT_KEY, 8'hFE);
		sys_in.standby_select_bit = 1'b1;
		eq.push_back(5'b00010);
		eq.push_back(5'b00001);
		eq.push_back(5'b00010);
		pulse(4); // run bit already clear
		pulse(3);
		wait_ev(20);
		wait_ev(200);
		sys_in.standby_select_bit = 1'b0;
		pulse(3);
		wait_ev(200);
		rd(`WIT_CSR_ADDR, 8'h00);
		pulse(3);
		repeat (4) @(posedge clk_sys);
		// one settling tick lands before the cleared select stops the count
		rd(`WIT_CNT_ADDR, 8'h01);
		// pll settling stops at 00 or 01
		for (int x = 0; x < 2; x++) begin
			sys_in.ratio_extra_tick = x[0];
			wr(`WIT_CNT_ADDR, `WIT_CNT_KEY, 8'hFE);
			eq.push_back(5'b00010);
			pulse(1); // run bit clear, no transfer in flight
			wait_ev(20);
			repeat (4) @(posedge clk_sys);
			rd(`WIT_CNT_ADDR, 8'(x));
			rd(`WIT_CSR_ADDR, 8'h00);
		end
		// power-on pin in mid-run clears both registers
		wr(`WIT_CNT_ADDR, `WIT_CNT_KEY, 8'h11);
		wr(`WIT_CSR_ADDR, `WIT_CSR_KEY, 8'h85);
		rst_b = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		rd(`WIT_CNT_ADDR, 8'h00);
		rd(`WIT_CSR_ADDR, 8'h00);
		repeat (3) @(posedge clk_sys);
		tally_and_finish();
	end
endmodule // wit_timer_tb
